// file: pchp_pkg.sv
// constants and types for the card socket host port
package pchp_pkg;

    localparam int ADDR_W = 11;
    localparam int DATA_W = 16;
    localparam int SENSE_W = 4;
    localparam int TMR_W = 12;

    // positions of the card status pins in the sense vector
    localparam int SNS_WAIT = 0;
    localparam int SNS_RDY = 1;
    localparam int SNS_PROT = 2;
    localparam int SNS_BATT = 3;

    // clock rate and phase times
    localparam int CLK_MHZ = 250;
    localparam int SETUP_NS = 30;
    localparam int STROBE_NS = 100;
    localparam int HOLD_NS = 30;
    localparam int RECOVER_NS = 20;
    localparam int CARD_RESET_NS = 10000;

    // phase times, rounded up to whole cycles
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int CRST_CYC = (CARD_RESET_NS * CLK_MHZ + 999) / 1000;

    // timer loads: a phase lasts load+1 cycles
    localparam logic [TMR_W-1:0] SETUP_LOAD = TMR_W'(SETUP_CYC - 1);
    localparam logic [TMR_W-1:0] STROBE_LOAD = TMR_W'(STROBE_CYC - 1);
    localparam logic [TMR_W-1:0] HOLD_LOAD = TMR_W'(HOLD_CYC - 1);
    localparam logic [TMR_W-1:0] RECOVER_LOAD = TMR_W'(RECOVER_CYC - 1);
    localparam logic [TMR_W-1:0] CRST_LOAD = TMR_W'(CRST_CYC - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO = 12'h000;

    // pin levels, negated and asserted, and byte enable codes
    localparam logic PIN_NEG = 1'b1;
    localparam logic PIN_ASSERT = 1'b0;
    localparam logic [1:0] BE_BOTH = 2'h3;
    localparam logic [1:0] BE_ODD = 2'h2;
    localparam logic [1:0] BE_NONE = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_RECOVER
    } pchp_state_t;

endpackage

// file: pchp_sense_if.sv
// synchronised card status and data, from the synchroniser to the port
interface pchp_sense_if;
    logic [pchp_pkg::SENSE_W-1:0] sense;
    logic [pchp_pkg::DATA_W-1:0] data;
    modport drv (output sense, output data);
    modport use_side (input sense, input data);
endinterface

// file: pchp_sync.sv
// two-flop synchronisers for every card input
module pchp_sync (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [pchp_pkg::SENSE_W-1:0] sense_pin,
    input wire logic [pchp_pkg::DATA_W-1:0] data_pin,
    pchp_sense_if.drv out
);
    localparam int W = pchp_pkg::SENSE_W + pchp_pkg::DATA_W;

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] stable_reg;
    logic [W-1:0] stable_next;

    always_comb begin
        meta_next = {sense_pin, data_pin};
        stable_next = meta_reg;
    end

    // status pins idle high, so they reset high to avoid a false wait
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '1;
            stable_reg <= '1;
        end else begin
            meta_reg <= meta_next;
            stable_reg <= stable_next;
        end
    end

    assign out.sense = stable_reg[W-1:pchp_pkg::DATA_W];
    assign out.data = stable_reg[pchp_pkg::DATA_W-1:0];
endmodule

// file: pchp_timer.sv
// down counter for phase lengths; done while the count is zero
module pchp_timer #(
    parameter logic [pchp_pkg::TMR_W-1:0] RESET_VAL = pchp_pkg::TMR_ZERO
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [pchp_pkg::TMR_W-1:0] value,
    output logic done
);
    logic [pchp_pkg::TMR_W-1:0] count_reg;
    logic [pchp_pkg::TMR_W-1:0] count_next;

    always_comb begin
        if (load) begin
            count_next = value;
        end else if (count_reg != pchp_pkg::TMR_ZERO) begin
            count_next = count_reg - 1'b1;
        end else begin
            count_next = count_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= RESET_VAL;
        end else begin
            count_reg <= count_next;
        end
    end

    assign done = (count_reg == pchp_pkg::TMR_ZERO);
endmodule

// file: pchp_port.sv
// host port that runs memory and I/O cycles on a plugged-in flash card
// What this block does
// RL1: even byte select low while even byte valid
// RL2: odd byte select low while odd byte valid, on memory cycles and on I/O ports with the 16-bit grant
// RL3: memory cycles: space select low attribute, high common
// RL4: space select held low for I/O cycles
// RL5: memory read strobe pulsed for memory reads
// RL6: memory write strobe pulsed for memory writes
// RL7: I/O read strobe for I/O reads only
// RL8: I/O write strobe for I/O writes only
// RL9: card wait low holds cycle and strobe open
// RL10: memory mode: shared input is card ready
// RL11: I/O mode: shared input low is interrupt request
// RL12: memory mode: shared input is write protect
// RL13: I/O mode: shared input grants 16-bit port access
// RL14: memory mode: shared input is battery condition
// RL15: I/O mode: shared input low is status change
// RL16: card reset output initialises the card
// RL17: enabled card interrupt forwarded as interrupt line
// RL18: one strobe at most, none while idle
module pchp_port (
    input wire logic clock,
    input wire logic rst_n,
    // user request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_io,
    input wire logic req_attr,
    input wire logic [1:0] req_be,
    input wire logic [pchp_pkg::ADDR_W-1:0] req_addr,
    input wire logic [pchp_pkg::DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [pchp_pkg::DATA_W-1:0] rsp_rdata,
    // mode and control
    input wire logic card_io_mode,
    input wire logic card_irq_enable,
    input wire logic card_reset_req,
    // card pins
    output logic [pchp_pkg::ADDR_W-1:0] card_addr,
    input wire logic [pchp_pkg::DATA_W-1:0] card_data_in,
    output logic [pchp_pkg::DATA_W-1:0] card_data_out,
    output logic card_data_oe,
    output logic card_even_byte_select_n,
    output logic card_odd_byte_select_n,
    output logic card_space_select_n,
    output logic card_mem_read_strobe_n,
    output logic card_mem_write_strobe_n,
    output logic card_io_read_strobe_n,
    output logic card_io_write_strobe_n,
    input wire logic card_wait_request_n,
    input wire logic card_ready_or_irq_n,
    input wire logic card_protect_or_width_n,
    input wire logic card_battery_or_status_n,
    output logic card_reset_out,
    // decoded card status
    output logic ready_irq_line_n,
    output logic card_ready,
    output logic card_write_protect,
    output logic card_io16_ok,
    output logic card_battery_ok,
    output logic card_status_change
);
    pchp_sense_if sns ();

    pchp_pkg::pchp_state_t state_reg;
    pchp_pkg::pchp_state_t state_next;
    logic [pchp_pkg::ADDR_W-1:0] addr_reg;
    logic [pchp_pkg::ADDR_W-1:0] addr_next;
    logic [pchp_pkg::DATA_W-1:0] wdata_reg;
    logic [pchp_pkg::DATA_W-1:0] wdata_next;
    logic [pchp_pkg::DATA_W-1:0] rdata_reg;
    logic [pchp_pkg::DATA_W-1:0] rdata_next;
    logic write_reg;
    logic write_next;
    logic io_reg;
    logic io_next;
    logic attr_reg;
    logic attr_next;
    logic [1:0] be_reg;
    logic [1:0] be_next;
    logic narrow_reg;
    logic narrow_next;
    logic split_reg;
    logic split_next;
    logic req_ready_reg;
    logic req_ready_next;
    logic rsp_valid_reg;
    logic rsp_valid_next;
    logic oe_reg;
    logic oe_next;
    logic [pchp_pkg::DATA_W-1:0] dout_reg;
    logic [pchp_pkg::DATA_W-1:0] dout_next;
    logic even_sel_reg;
    logic even_sel_next;
    logic odd_sel_reg;
    logic odd_sel_next;
    logic space_reg;
    logic space_next;
    logic mrd_reg;
    logic mrd_next;
    logic mwr_reg;
    logic mwr_next;
    logic iord_reg;
    logic iord_next;
    logic iowr_reg;
    logic iowr_next;
    logic phase_load;
    logic [pchp_pkg::TMR_W-1:0] phase_value;
    logic phase_done;
    logic crst_load;
    logic crst_done;
    logic crst_reg;
    logic crst_next;
    logic [5:0] status_reg;
    logic [5:0] status_next;
    logic port8;
    logic wait_open;

    pchp_sync u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .sense_pin({card_battery_or_status_n, card_protect_or_width_n,
                    card_ready_or_irq_n, card_wait_request_n}),
        .data_pin(card_data_in),
        .out(sns)
    );

    pchp_timer u_phase (
        .clock(clock),
        .rst_n(rst_n),
        .load(phase_load),
        .value(phase_value),
        .done(phase_done)
    );

    // card reset runs from power-up so the card starts known
    pchp_timer #(.RESET_VAL(pchp_pkg::CRST_LOAD)) u_crst (
        .clock(clock),
        .rst_n(rst_n),
        .load(crst_load),
        .value(pchp_pkg::CRST_LOAD),
        .done(crst_done)
    );

    // an I/O port without the 16-bit grant takes bytes on the low lane
    assign port8 = sns.sense[pchp_pkg::SNS_PROT]; // [RL13]
    assign wait_open = !sns.sense[pchp_pkg::SNS_WAIT];

    always_comb begin
        crst_load = card_reset_req && (state_reg == pchp_pkg::ST_IDLE)
            && !crst_reg;
        crst_next = crst_load || !crst_done; // [RL16]
    end

    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        write_next = write_reg;
        io_next = io_reg;
        attr_next = attr_reg;
        be_next = be_reg;
        narrow_next = narrow_reg;
        split_next = split_reg;
        rsp_valid_next = 1'b0;
        oe_next = oe_reg;
        dout_next = dout_reg;
        even_sel_next = even_sel_reg;
        odd_sel_next = odd_sel_reg;
        space_next = space_reg;
        mrd_next = pchp_pkg::PIN_NEG;
        mwr_next = pchp_pkg::PIN_NEG;
        iord_next = pchp_pkg::PIN_NEG;
        iowr_next = pchp_pkg::PIN_NEG;
        phase_load = 1'b0;
        phase_value = pchp_pkg::SETUP_LOAD;
        case (state_reg)
            pchp_pkg::ST_IDLE: begin
                if (req_valid && req_ready_reg
                    && req_be != pchp_pkg::BE_NONE) begin
                    write_next = req_write;
                    io_next = req_io;
                    attr_next = req_attr;
                    be_next = req_be;
                    wdata_next = req_wdata;
                    rdata_next = '0;
                    narrow_next = req_io && port8
                        && req_be == pchp_pkg::BE_ODD;
                    split_next = req_io && port8
                        && req_be == pchp_pkg::BE_BOTH;
                    addr_next = {req_addr[pchp_pkg::ADDR_W-1:1],
                                 narrow_next};
                    even_sel_next = !(req_be[0] || narrow_next); // [RL1]
                    odd_sel_next = !(req_be[1] && !narrow_next
                        && !split_next); // [RL2]
                    // attribute low, common high; I/O always low
                    space_next = req_io ? pchp_pkg::PIN_ASSERT
                        : !req_attr; // [RL3] [RL4]
                    oe_next = req_write;
                    dout_next = narrow_next
                        ? {req_wdata[15:8], req_wdata[15:8]} : req_wdata;
                    phase_load = 1'b1;
                    phase_value = pchp_pkg::SETUP_LOAD;
                    state_next = pchp_pkg::ST_SETUP;
                end
            end
            pchp_pkg::ST_SETUP: begin
                if (phase_done) begin
                    phase_load = 1'b1;
                    phase_value = pchp_pkg::STROBE_LOAD;
                    state_next = pchp_pkg::ST_STROBE;
                end
            end
            pchp_pkg::ST_STROBE: begin
                // strobe stays low until time is up and wait is gone
                if (phase_done && !wait_open) begin // [RL9]
                    if (!write_reg) begin
                        if (narrow_reg) begin
                            rdata_next[15:8] = sns.data[7:0];
                        end else begin
                            rdata_next[7:0] = be_reg[0]
                                ? sns.data[7:0] : rdata_reg[7:0];
                            rdata_next[15:8] = be_reg[1] && !split_reg
                                ? sns.data[15:8] : rdata_reg[15:8];
                        end
                    end
                    phase_load = 1'b1;
                    phase_value = pchp_pkg::HOLD_LOAD;
                    state_next = pchp_pkg::ST_HOLD;
                end else begin
                    mrd_next = !(!io_reg && !write_reg); // [RL5]
                    mwr_next = !(!io_reg && write_reg); // [RL6]
                    iord_next = !(io_reg && !write_reg); // [RL7]
                    iowr_next = !(io_reg && write_reg); // [RL8]
                end
            end
            pchp_pkg::ST_HOLD: begin
                if (phase_done && split_reg) begin
                    // second half of a split word: odd byte, low lane
                    split_next = 1'b0;
                    narrow_next = 1'b1;
                    addr_next = {addr_reg[pchp_pkg::ADDR_W-1:1], 1'b1};
                    dout_next = {wdata_reg[15:8], wdata_reg[15:8]};
                    phase_load = 1'b1;
                    phase_value = pchp_pkg::SETUP_LOAD;
                    state_next = pchp_pkg::ST_SETUP;
                end else if (phase_done) begin
                    even_sel_next = pchp_pkg::PIN_NEG;
                    odd_sel_next = pchp_pkg::PIN_NEG;
                    space_next = pchp_pkg::PIN_NEG;
                    oe_next = 1'b0;
                    rsp_valid_next = 1'b1;
                    phase_load = 1'b1;
                    phase_value = pchp_pkg::RECOVER_LOAD;
                    state_next = pchp_pkg::ST_RECOVER;
                end
            end
            pchp_pkg::ST_RECOVER: begin
                if (phase_done) begin
                    state_next = pchp_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = pchp_pkg::ST_IDLE;
                even_sel_next = pchp_pkg::PIN_NEG;
                odd_sel_next = pchp_pkg::PIN_NEG;
                space_next = pchp_pkg::PIN_NEG;
                oe_next = 1'b0;
            end
        endcase
        // no new cycle is taken while the card is held in reset
        req_ready_next = (state_next == pchp_pkg::ST_IDLE) && !crst_next;
    end

    // shared inputs change meaning with the card mode
    always_comb begin
        status_next[0] = !(card_irq_enable && card_io_mode
            && !sns.sense[pchp_pkg::SNS_RDY]); // [RL17] [RL11]
        status_next[1] = !card_io_mode
            && sns.sense[pchp_pkg::SNS_RDY]; // [RL10]
        status_next[2] = !card_io_mode
            && sns.sense[pchp_pkg::SNS_PROT]; // [RL12]
        status_next[3] = card_io_mode
            && !sns.sense[pchp_pkg::SNS_PROT]; // [RL13]
        status_next[4] = !card_io_mode
            && sns.sense[pchp_pkg::SNS_BATT]; // [RL14]
        status_next[5] = card_io_mode
            && !sns.sense[pchp_pkg::SNS_BATT]; // [RL15]
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pchp_pkg::ST_IDLE;
            addr_reg <= '0;
            wdata_reg <= '0;
            rdata_reg <= '0;
            write_reg <= 1'b0;
            io_reg <= 1'b0;
            attr_reg <= 1'b0;
            be_reg <= pchp_pkg::BE_NONE;
            narrow_reg <= 1'b0;
            split_reg <= 1'b0;
            req_ready_reg <= 1'b0;
            rsp_valid_reg <= 1'b0;
            oe_reg <= 1'b0;
            dout_reg <= '0;
            even_sel_reg <= pchp_pkg::PIN_NEG;
            odd_sel_reg <= pchp_pkg::PIN_NEG;
            space_reg <= pchp_pkg::PIN_NEG;
            mrd_reg <= pchp_pkg::PIN_NEG;
            mwr_reg <= pchp_pkg::PIN_NEG;
            iord_reg <= pchp_pkg::PIN_NEG;
            iowr_reg <= pchp_pkg::PIN_NEG;
            crst_reg <= 1'b1;
            status_reg <= 6'h01;
        end else begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            write_reg <= write_next;
            io_reg <= io_next;
            attr_reg <= attr_next;
            be_reg <= be_next;
            narrow_reg <= narrow_next;
            split_reg <= split_next;
            req_ready_reg <= req_ready_next;
            rsp_valid_reg <= rsp_valid_next;
            oe_reg <= oe_next;
            dout_reg <= dout_next;
            even_sel_reg <= even_sel_next;
            odd_sel_reg <= odd_sel_next;
            space_reg <= space_next;
            mrd_reg <= mrd_next; // [RL18]
            mwr_reg <= mwr_next;
            iord_reg <= iord_next;
            iowr_reg <= iowr_next;
            crst_reg <= crst_next;
            status_reg <= status_next;
        end
    end

    assign req_ready = req_ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rdata_reg;
    assign card_addr = addr_reg;
    assign card_data_out = dout_reg;
    assign card_data_oe = oe_reg;
    assign card_even_byte_select_n = even_sel_reg;
    assign card_odd_byte_select_n = odd_sel_reg;
    assign card_space_select_n = space_reg;
    assign card_mem_read_strobe_n = mrd_reg;
    assign card_mem_write_strobe_n = mwr_reg;
    assign card_io_read_strobe_n = iord_reg;
    assign card_io_write_strobe_n = iowr_reg;
    assign card_reset_out = crst_reg;
    assign ready_irq_line_n = status_reg[0];
    assign card_ready = status_reg[1];
    assign card_write_protect = status_reg[2];
    assign card_io16_ok = status_reg[3];
    assign card_battery_ok = status_reg[4];
    assign card_status_change = status_reg[5];
endmodule

// file: pchp_monitor.sv
// checker for the card socket host port, watching its pins
module pchp_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic req_ready,
    input wire logic card_io_mode,
    input wire logic card_irq_enable,
    input wire logic card_even_byte_select_n,
    input wire logic card_odd_byte_select_n,
    input wire logic card_space_select_n,
    input wire logic card_mem_read_strobe_n,
    input wire logic card_mem_write_strobe_n,
    input wire logic card_io_read_strobe_n,
    input wire logic card_io_write_strobe_n,
    input wire logic card_wait_request_n,
    input wire logic card_reset_out,
    input wire logic ready_irq_line_n,
    input wire logic card_ready,
    input wire logic card_io16_ok,
    input wire logic card_status_change
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [3:0] stb;
    assign stb = ~{card_mem_read_strobe_n, card_mem_write_strobe_n,
        card_io_read_strobe_n, card_io_write_strobe_n};
    sequence mrd_low8;
        !card_mem_read_strobe_n [*8];
    endsequence
    // four cycles covers the two-flop lag on the wait pin
    sequence card_stalled;
        (!card_wait_request_n && stb != 4'h0) [*4];
    endsequence
    one_strobe_a: assert property ($onehot0(stb))
        else $error("two strobes low");
    idle_quiet_a: assert property (req_ready |-> stb == 4'h0)
        else $error("strobe low while port idle");
    io_space_a: assert property (stb[1:0] != 2'h0 |-> !card_space_select_n)
        else $error("space select high in io cycle");
    strobe_sel_a: assert property (stb != 4'h0 |->
        !(card_even_byte_select_n && card_odd_byte_select_n))
        else $error("strobe without byte select");
    mrd_width_a: assert property ($fell(card_mem_read_strobe_n) |->
        mrd_low8 ##16 !card_mem_read_strobe_n)
        else $error("memory read strobe too short");
    wait_hold_a: assert property (card_stalled |=> stb != 4'h0)
        else $error("cycle ended while card waits");
    irq_fwd_a: assert property (!ready_irq_line_n |->
        $past(card_io_mode && card_irq_enable))
        else $error("stray interrupt");
    mem_decode_a: assert property (card_ready |-> $past(!card_io_mode))
        else $error("card ready shown in io mode");
    io_decode_a: assert property (card_io16_ok || card_status_change |->
        $past(card_io_mode))
        else $error("io status shown in memory mode");
    reset_block_a: assert property (card_reset_out |-> !req_ready)
        else $error("request taken during card reset");
endmodule

// file: pchp_card_model.sv
// behavioural flash card: word store, read data and wait stretching
module pchp_card_model (
    input wire logic clock,
    input wire logic [pchp_pkg::ADDR_W-1:0] card_addr,
    input wire logic [pchp_pkg::DATA_W-1:0] card_data_out,
    input wire logic [1:0] sel_n,
    input wire logic [3:0] stb,
    input wire logic [7:0] stall_cycles,
    output logic [pchp_pkg::DATA_W-1:0] card_data_in,
    output logic card_wait_request_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:1023];
    logic [15:0] last = 16'h0000;
    logic [7:0] cnt = 8'h00;
    logic was_low = 1'b0;
    initial for (int i = 0; i < 1024; i++) mem[i] = 16'h0000;
    initial card_data_in = 16'h0000;
    assign card_wait_request_n = (cnt == 8'h00);
    always @(posedge clock) begin
        was_low <= (stb != 4'h0);
        if (stb != 4'h0 && !was_low) cnt <= stall_cycles;
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
        if (stb[3] || stb[1]) begin
            card_data_in <= mem[card_addr[10:1]];
            last <= mem[card_addr[10:1]];
        end else begin
            // released bus shows the inverse
            card_data_in <= ~last;
        end
        if (stb[2] || stb[0]) begin
            if (!sel_n[0]) mem[card_addr[10:1]][7:0] <= card_data_out[7:0];
            if (!sel_n[1]) mem[card_addr[10:1]][15:8] <= card_data_out[15:8];
        end
    end
endmodule

// file: tb_pchp.sv
// self-checking bench for the card socket host port
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, rst_n = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_io = 1'b0, req_attr = 1'b0;
    logic [1:0] req_be = 2'h3;
    logic [10:0] req_addr = 11'h000;
    logic [15:0] req_wdata = 16'h0000, rsp_rdata, card_data_in, card_data_out;
    logic req_ready, rsp_valid, card_data_oe, card_reset_out;
    logic card_io_mode = 1'b0, card_irq_enable = 1'b0, card_reset_req = 1'b0;
    logic [10:0] card_addr;
    logic sel_e, sel_o, space_n, mr_n, mw_n, ir_n, iw_n, wait_n;
    logic rdy_n = 1'b1, prot_n = 1'b0, batt_n = 1'b1;
    logic irq_n, c_rdy, c_wp, c_io16, c_batt, c_chg;
    logic [7:0] stall = 8'h00;
    logic [3:0] stb, seen_stb;
    logic [1:0] seen_sel;
    logic seen_space, seen_oe;
    logic [15:0] shadow [0:1023];
    logic [31:0] seed = 32'd13;
    int num_errors = 0, num_checks = 0, wid = 0, cyc = 0;
    always #2 clock = ~clock;
    assign stb = ~{mr_n, mw_n, ir_n, iw_n};
    pchp_port dut (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_io(req_io),
        .req_attr(req_attr), .req_be(req_be), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .card_io_mode(card_io_mode), .card_irq_enable(card_irq_enable),
        .card_reset_req(card_reset_req), .card_addr(card_addr),
        .card_data_in(card_data_in), .card_data_out(card_data_out),
        .card_data_oe(card_data_oe), .card_even_byte_select_n(sel_e),
        .card_odd_byte_select_n(sel_o), .card_space_select_n(space_n),
        .card_mem_read_strobe_n(mr_n), .card_mem_write_strobe_n(mw_n),
        .card_io_read_strobe_n(ir_n), .card_io_write_strobe_n(iw_n),
        .card_wait_request_n(wait_n), .card_ready_or_irq_n(rdy_n),
        .card_protect_or_width_n(prot_n), .card_battery_or_status_n(batt_n),
        .card_reset_out(card_reset_out), .ready_irq_line_n(irq_n),
        .card_ready(c_rdy), .card_write_protect(c_wp), .card_io16_ok(c_io16),
        .card_battery_ok(c_batt), .card_status_change(c_chg));
    pchp_card_model card (.clock(clock), .card_addr(card_addr),
        .card_data_out(card_data_out), .sel_n({sel_o, sel_e}), .stb(stb),
        .stall_cycles(stall), .card_data_in(card_data_in),
        .card_wait_request_n(wait_n));
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (stb != 4'h0) begin
            wid <= wid + 1;
            seen_stb <= stb;
            seen_sel <= {sel_o, sel_e};
            seen_space <= space_n;
            seen_oe <= card_data_oe;
        end
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic op(input logic wr, io, attr, input logic [1:0] be,
        input logic [10:0] a, input logic [15:0] wd);
        int n;
        logic [3:0] es;
        wid = 0;
        n = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        {req_write, req_io, req_attr, req_be, req_addr} <= {wr, io, attr, be, a};
        req_wdata <= wd;
        do begin @(posedge clock); n++; end while (req_ready !== 1'b1 && n < 4000);
        req_valid <= 1'b0;
        do begin @(posedge clock); n++; end while (rsp_valid !== 1'b1 && n < 4000);
        es = wr ? (io ? 4'h1 : 4'h4) : (io ? 4'h2 : 4'h8);
        check("data drive", 16'(seen_oe), 16'(wr));
        check("strobe kind", 16'(seen_stb), 16'(es));
        check("space select", 16'(seen_space), 16'(!(io || attr)));
        check("byte selects", 16'(seen_sel), 16'({~be}));
        if (stall == 8'h00) check("strobe width", 16'(wid), 16'(pchp_pkg::STROBE_CYC - 1));
        else check("stretched", 16'(wid >= int'(stall)), 16'h0001);
        if (!wr && be == 2'h3) check("read data", rsp_rdata, shadow[a[10:1]]);
        if (wr && be[0]) shadow[a[10:1]][7:0] = wd[7:0];
        if (wr && be[1]) shadow[a[10:1]][15:8] = wd[15:8];
    endtask
    initial begin
        logic [31:0] r;
        logic [5:0] ex;
        for (int i = 0; i < 1024; i++) shadow[i] = 16'h0000;
        repeat (4) @(posedge clock);
        check("idle strobes", 16'(stb), 16'h0000);
        check("card reset", 16'(card_reset_out), 16'h0001);
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int n = 0; n < 3000 && req_ready !== 1'b1; n++) @(posedge clock);
        check("reset done", 16'(card_reset_out), 16'h0000);
        $display("test reset done");
        op(1'b1, 1'b0, 1'b0, 2'h1, 11'h006, 16'hA5C3);
        op(1'b1, 1'b0, 1'b1, 2'h2, 11'h006, 16'h5A3C);
        op(1'b0, 1'b0, 1'b0, 2'h3, 11'h006, 16'h0000);
        op(1'b0, 1'b1, 1'b0, 2'h1, 11'h006, 16'h0000);
        $display("test byte lanes done");
        for (int i = 0; i < 16; i++) begin
            r = xs();
            op(r[0], r[1], r[2], 2'h3, 11'({r[6:4], 1'b0}), r[31:16]);
        end
        $display("test random cycles done");
        stall <= 8'd40;
        op(1'b0, 1'b1, 1'b0, 2'h3, 11'h002, 16'h0000);
        stall <= 8'h00;
        $display("test wait stretch done");
        for (int i = 0; i < 32; i++) begin
            @(posedge clock);
            {card_irq_enable, card_io_mode, batt_n, prot_n, rdy_n} <= 5'(i);
            repeat (5) @(posedge clock);
            ex = {!(i[3] && i[4] && !i[0]), !i[3] && i[0], !i[3] && i[1],
                i[3] && !i[1], !i[3] && i[2], i[3] && !i[2]};
            check("status", 16'({irq_n, c_rdy, c_wp, c_io16, c_batt, c_chg}),
                16'(ex));
        end
        $display("test status decode done");
        @(posedge clock);
        card_reset_req <= 1'b1;
        @(posedge clock);
        card_reset_req <= 1'b0;
        repeat (2) @(posedge clock);
        check("card reset pulse", 16'({card_reset_out, req_ready}), 16'h0002);
        for (int n = 0; n < 3000 && req_ready !== 1'b1; n++) @(posedge clock);
        check("card reset end", 16'(card_reset_out), 16'h0000);
        $display("test card reset done");
        final_report();
    end
endmodule
bind pchp_port pchp_monitor mon (.*);
